/* rtl/cia_consts.vh */
// Constants for the commutation angle block: register offsets, field
// positions, reset values and angle/timing figures.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef CIA_CONSTS_VH
`define CIA_CONSTS_VH

// Register byte offsets on the AXI4-Lite slave
`define CIA_REG_CTRL      8'h00
`define CIA_REG_STATUS    8'h04
`define CIA_REG_KP        8'h08
`define CIA_REG_KI        8'h0C
`define CIA_REG_I_INIT    8'h10
`define CIA_REG_I_FINAL   8'h14
`define CIA_REG_RAMP_SEC  8'h18
`define CIA_REG_SRCH_SEC  8'h1C
`define CIA_REG_CMD_CUR   8'h20
`define CIA_REG_POLES     8'h24
`define CIA_REG_STEP      8'h28
`define CIA_REG_ANGLE     8'h2C
`define CIA_REG_ENC_POS   8'h30

// Control register fields
`define CIA_CTRL_METHOD   0
`define CIA_CTRL_START    1
`define CIA_CTRL_MOTION   2

// Status register fields
`define CIA_ST_VALID      0
`define CIA_ST_REFINED    1
`define CIA_ST_HALL_FLT   2
`define CIA_ST_MULTI_FLT  3
`define CIA_ST_BUSY       4
`define CIA_ST_HALL_LSB   8

// Reset values and the Kp write ceiling
`define CIA_KP_RESET      16'h0400
`define CIA_KP_MAX        16'h7FFF
`define CIA_KI_RESET      16'h0000
`define CIA_POLES_RESET   8'h04
`define CIA_STEP_RESET    16'h0010

// Angle scale: 16'h0000..16'hFFFF spans 360 electrical degrees
`define CIA_DEG30         16'h1555
`define CIA_DEG60         16'h2AAB
`define CIA_DEG120        16'h5555
`define CIA_DEG240        16'hAAAB

// Clock: period in ns and one second in ns
`define CIA_CLK_PERIOD_NS 32'h0000_0004
`define CIA_NS_PER_SEC    32'h3B9A_CA00

// Bus answers
`define CIA_RESP_OKAY     2'h0
`define CIA_RESP_SLVERR   2'h2

`endif

/* rtl/cia_sine.v */
// Three-phase sinusoidal current reference generator.
// Assumes angle and amplitude come from logic on the same clock.
`include "cia_consts.vh"

module cia_sine (
  // Clock and reset
  input  wire               aclk,
  input  wire               aresetn,
  // Angle and amplitude
  input  wire        [15:0] angle,
  input  wire        [15:0] amp,
  // Phase current references
  output reg  signed [15:0] phase_r_current,
  output reg  signed [15:0] phase_s_current,
  output reg  signed [15:0] phase_t_current
);

  // Parabolic sine, Q15 result, sign from the upper half-turn
  function signed [15:0] sinq;
    input [15:0] p;
    reg   [14:0] h;
    reg   [29:0] prod;
    reg   [15:0] mag;
    begin
      h = p[14:0];
      prod = h * (16'h8000 - {1'b0, h});
      mag = (prod[29:13] > 17'h0_7FFF) ? 16'h7FFF : prod[28:13];
      sinq = p[15] ? -$signed(mag) : $signed(mag);
    end
  endfunction

  // Amplitude times sine, scaled back by 2^15
  function signed [15:0] scale;
    input [15:0] a;
    input [15:0] ph;
    reg signed [32:0] m;
    begin
      m = $signed({1'b0, a}) * sinq(ph);
      scale = m[30:15];
    end
  endfunction

  // Phases at 0, -120 and -240 degrees for positive rotation
  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_r_current <= 16'sh0000;
      phase_s_current <= 16'sh0000;
      phase_t_current <= 16'sh0000;
    end else begin
      phase_r_current <= scale(amp, angle);
      phase_s_current <= scale(amp, angle - `CIA_DEG120);
      phase_t_current <= scale(amp, angle - `CIA_DEG240);
    end
  end

endmodule

/* rtl/cia_top.v */
// Commutation angle initialisation and tracking, with AXI4-Lite registers.
// Assumes Hall and encoder pins are asynchronous; bus on aclk.
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "cia_consts.vh"

module cia_top #(
  parameter [31:0] CLK_HZ = `CIA_NS_PER_SEC / `CIA_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire               aclk,
  input  wire               aresetn,
  // AXI4-Lite write channels
  input  wire         [7:0] s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  input  wire        [31:0] s_axi_wdata,
  input  wire         [3:0] s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  output reg          [1:0] s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  // AXI4-Lite read channels
  input  wire         [7:0] s_axi_araddr,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  output reg         [31:0] s_axi_rdata,
  output reg          [1:0] s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  // Sensor pins
  input  wire         [2:0] hall_in,
  input  wire               enc_a,
  input  wire               enc_b,
  // Phase current references
  output wire signed [15:0] phase_r_current,
  output wire signed [15:0] phase_s_current,
  output wire signed [15:0] phase_t_current
);

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_HALL = 5'b00010;
  localparam [4:0] ST_SRCH = 5'b00100;
  localparam [4:0] ST_RET  = 5'b01000;
  localparam [4:0] ST_RUN  = 5'b10000;

  // Byte-lane merge of a write into a register
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i]) wmerge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // Lane merge into a 16-bit register
  function [15:0] wlow;
    input [15:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    wlow = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  // Hall code to sector, 3'd7 for an unused code
  function [2:0] hall_sector;
    input [2:0] c;
    begin
      case (c)
        3'b001:  hall_sector = 3'd0;
        3'b011:  hall_sector = 3'd1;
        3'b010:  hall_sector = 3'd2;
        3'b110:  hall_sector = 3'd3;
        3'b100:  hall_sector = 3'd4;
        3'b101:  hall_sector = 3'd5;
        default: hall_sector = 3'd7;
      endcase
    end
  endfunction

  // Start angle of a sector
  function [15:0] sector_angle;
    input [2:0] s;
    reg   [18:0] m;
    begin
      m = s * `CIA_DEG60;
      sector_angle = m[15:0];
    end
  endfunction

  // Registers
  reg        method;
  reg        motion;
  reg        start_pls;
  reg [15:0] kp;
  reg [15:0] ki;
  reg [15:0] i_init;
  reg [15:0] i_final;
  reg [15:0] ramp_sec;
  reg [15:0] srch_sec;
  reg [15:0] cmd_cur;
  reg  [7:0] poles;
  reg [15:0] step;
  reg        angle_ok;
  reg        refined;
  reg        hall_flt;
  reg        multi_flt;

  // Synchronisers
  reg  [2:0] hall_m;
  reg  [2:0] hall_s;
  reg  [2:0] hall_prev;
  reg  [1:0] enc_m;
  reg  [1:0] enc_s;
  reg  [1:0] enc_prev;

  // Tracking and search state
  reg  [4:0] state;
  reg [15:0] elec;
  reg  [7:0] turn;
  reg signed [15:0] enc_pos;
  reg signed [15:0] home_pos;
  reg signed [31:0] integ;
  reg [15:0] cur;
  reg [47:0] acc;
  reg [31:0] cyc_cnt;
  reg [15:0] sec_cnt;

  // AXI write holding
  reg        aw_hold;
  reg  [7:0] aw_addr;
  reg        w_hold;
  reg [31:0] w_data;
  reg  [3:0] w_strb;

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire do_wr = aw_hold && w_hold && !s_axi_bvalid;
  wire [31:0] wv = wmerge({16'h0000, kp}, w_data, w_strb);
  wire wr_ctrl = do_wr && aw_addr == `CIA_REG_CTRL;
  wire wr_stat = do_wr && aw_addr == `CIA_REG_STATUS;

  // Encoder decode: gray order 00,01,11,10 counts up
  wire [3:0] qd = {enc_prev, enc_s};
  wire enc_up = qd == 4'b0001 || qd == 4'b0111 || qd == 4'b1110 || qd == 4'b1000;
  wire enc_dn = qd == 4'b0010 || qd == 4'b1011 || qd == 4'b1101 || qd == 4'b0100;

  // Hall checks
  wire [2:0] hall_x   = hall_s ^ hall_prev;
  wire [1:0] hall_pop = {1'b0, hall_x[0]} + {1'b0, hall_x[1]} + {1'b0, hall_x[2]};
  wire hall_bad  = hall_sector(hall_s) == 3'd7;
  wire hall_one  = hall_pop == 2'd1 && !hall_bad;
  wire hall_many = hall_pop > 2'd1;
  wire [2:0] sec_new = hall_sector(hall_s);
  wire [2:0] sec_old = hall_sector(hall_prev);
  wire fwd = sec_new == ((sec_old == 3'd5) ? 3'd0 : sec_old + 3'd1);
  wire [15:0] bound = fwd ? sector_angle(sec_new) : sector_angle(sec_old);

  // Electrical angle steps with wrap detection
  wire [16:0] up_sum = {1'b0, elec} + {1'b0, step};
  wire [16:0] dn_dif = {1'b0, elec} - {1'b0, step};
  wire  [6:0] pairs  = poles[7:1];

  // Mechanical angle from turn count and electrical angle
  wire [24:0] mech_num = {turn, elec, 1'b0};
  wire [24:0] mech_q   = (poles == 8'h00) ? 25'h000_0000 : mech_num / poles;
  wire [15:0] mech     = mech_q[15:0];

  // Search loop: field angle from shaft error
  wire signed [15:0] err = home_pos - enc_pos;
  wire signed [47:0] u   = $signed({1'b0, kp}) * err + $signed({1'b0, ki}) * integ;
  wire [15:0] field_ang  = u[25:10];
  wire [15:0] delta      = i_final - i_init;
  wire [47:0] ramp_cyc   = ramp_sec * CLK_HZ;
  wire [47:0] acc_nx     = acc + {32'h0000_0000, delta};
  wire sec_tick = cyc_cnt == CLK_HZ - 32'h0000_0001;

  // Drive of the phase generator
  wire searching = (state == ST_SRCH) || (state == ST_RET);
  wire [15:0] drv_ang = searching ? field_ang : elec;
  wire [15:0] drv_amp = searching ? cur : ((state == ST_RUN && motion) ? cmd_cur : 16'h0000);

  cia_sine u_sine (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .angle           (drv_ang),
    .amp             (drv_amp),
    .phase_r_current (phase_r_current),
    .phase_s_current (phase_s_current),
    .phase_t_current (phase_t_current)
  );

  // Pin synchronisers, two stages each
  always @(posedge aclk) begin
    if (!aresetn) begin
      hall_m    <= 3'h0;
      hall_s    <= 3'h0;
      hall_prev <= 3'h0;
      enc_m     <= 2'h0;
      enc_s     <= 2'h0;
      enc_prev  <= 2'h0;
    end else begin
      hall_m    <= hall_in;
      hall_s    <= hall_m;
      hall_prev <= hall_s;
      enc_m     <= {enc_a, enc_b};
      enc_s     <= enc_m;
      enc_prev  <= enc_s;
    end
  end

  // AXI write path and configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_hold  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CIA_RESP_OKAY;
      method    <= 1'b0;
      motion    <= 1'b0;
      start_pls <= 1'b0;
      kp       <= `CIA_KP_RESET;
      ki       <= `CIA_KI_RESET;
      i_init   <= 16'h0000;
      i_final  <= 16'h0000;
      ramp_sec <= 16'h0000;
      srch_sec <= 16'h0000;
      cmd_cur  <= 16'h0000;
      poles    <= `CIA_POLES_RESET;
      step     <= `CIA_STEP_RESET;
    end else begin
      start_pls <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_wr) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `CIA_RESP_OKAY;
        case (aw_addr)
          `CIA_REG_CTRL: begin
            if (w_strb[0]) begin
              method    <= w_data[`CIA_CTRL_METHOD];
              motion    <= w_data[`CIA_CTRL_MOTION];
              start_pls <= w_data[`CIA_CTRL_START];
            end
          end
          `CIA_REG_STATUS:   ;
          `CIA_REG_KP:       kp <= (wv > {16'h0000, `CIA_KP_MAX}) ? `CIA_KP_MAX : wv[15:0];
          `CIA_REG_KI:       ki       <= wlow(ki, w_data, w_strb);
          `CIA_REG_I_INIT:   i_init   <= wlow(i_init, w_data, w_strb);
          `CIA_REG_I_FINAL:  i_final  <= wlow(i_final, w_data, w_strb);
          `CIA_REG_RAMP_SEC: ramp_sec <= wlow(ramp_sec, w_data, w_strb);
          `CIA_REG_SRCH_SEC: srch_sec <= wlow(srch_sec, w_data, w_strb);
          `CIA_REG_CMD_CUR:  cmd_cur  <= wlow(cmd_cur, w_data, w_strb);
          `CIA_REG_POLES:    poles    <= w_strb[0] ? w_data[7:0] : poles;
          `CIA_REG_STEP:     step     <= wlow(step, w_data, w_strb);
          `CIA_REG_ANGLE, `CIA_REG_ENC_POS: ;
          default: s_axi_bresp <= `CIA_RESP_SLVERR;
        endcase
      end
    end
  end

  // AXI read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CIA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `CIA_RESP_OKAY;
      case (s_axi_araddr)
        `CIA_REG_CTRL:     s_axi_rdata <= {29'h0, motion, 1'b0, method};
        `CIA_REG_STATUS:   s_axi_rdata <= {21'h0, hall_s, 3'h0, !(state[0] || state[4]),
                                           multi_flt, hall_flt, refined, angle_ok};
        `CIA_REG_KP:       s_axi_rdata <= {16'h0000, kp};
        `CIA_REG_KI:       s_axi_rdata <= {16'h0000, ki};
        `CIA_REG_I_INIT:   s_axi_rdata <= {16'h0000, i_init};
        `CIA_REG_I_FINAL:  s_axi_rdata <= {16'h0000, i_final};
        `CIA_REG_RAMP_SEC: s_axi_rdata <= {16'h0000, ramp_sec};
        `CIA_REG_SRCH_SEC: s_axi_rdata <= {16'h0000, srch_sec};
        `CIA_REG_CMD_CUR:  s_axi_rdata <= {16'h0000, cmd_cur};
        `CIA_REG_POLES:    s_axi_rdata <= {24'h00_0000, poles};
        `CIA_REG_STEP:     s_axi_rdata <= {16'h0000, step};
        `CIA_REG_ANGLE:    s_axi_rdata <= {mech, elec};
        `CIA_REG_ENC_POS:  s_axi_rdata <= {{16{enc_pos[15]}}, enc_pos};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `CIA_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Hall fault flags: set wins over a write-one clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      hall_flt  <= 1'b0;
      multi_flt <= 1'b0;
    end else begin
      hall_flt  <= (hall_bad && !method && !state[0]) ||
                   (hall_flt && !(wr_stat && w_strb[0] && w_data[`CIA_ST_HALL_FLT]));
      multi_flt <= (hall_many && !method && !state[0]) ||
                   (multi_flt && !(wr_stat && w_strb[0] && w_data[`CIA_ST_MULTI_FLT]));
    end
  end

  // Encoder position count
  always @(posedge aclk) begin
    if (!aresetn)
      enc_pos <= 16'sh0000;
    else if (enc_up)
      enc_pos <= enc_pos + 16'sh0001;
    else if (enc_dn)
      enc_pos <= enc_pos - 16'sh0001;
  end

  // Start-up sequencer and angle tracking
  always @(posedge aclk) begin
    if (!aresetn) begin
      state    <= ST_IDLE;
      elec     <= 16'h0000;
      turn     <= 8'h00;
      angle_ok <= 1'b0;
      refined  <= 1'b0;
      home_pos <= 16'sh0000;
      integ    <= 32'sh0000_0000;
      cur      <= 16'h0000;
      acc      <= 48'h0000_0000_0000;
      cyc_cnt  <= 32'h0000_0000;
      sec_cnt  <= 16'h0000;
    end else begin
      cyc_cnt <= sec_tick ? 32'h0000_0000 : cyc_cnt + 32'h0000_0001;
      if (sec_tick)
        sec_cnt <= sec_cnt + 16'h0001;
      if (start_pls) begin
        angle_ok <= 1'b0;
        refined  <= 1'b0;
        state    <= method ? ST_SRCH : ST_HALL;
        home_pos <= enc_pos;
        integ    <= 32'sh0000_0000;
        cur      <= i_init;
        acc      <= 48'h0000_0000_0000;
        cyc_cnt  <= 32'h0000_0000;
        sec_cnt  <= 16'h0000;
      end else begin
        case (state)
          ST_IDLE: ;
          ST_HALL: begin
            if (!hall_bad) begin
              elec     <= sector_angle(sec_new) + `CIA_DEG30;
              turn     <= 8'h00;
              angle_ok <= 1'b1;
              state    <= ST_RUN;
            end
          end
          ST_SRCH: begin
            integ <= integ + err;
            if (cur < i_final) begin
              if (acc_nx >= ramp_cyc) begin
                cur <= cur + 16'h0001;
                acc <= acc_nx - ramp_cyc;
              end else begin
                acc <= acc_nx;
              end
            end
            if (sec_tick && sec_cnt + 16'h0001 >= srch_sec)
              state <= ST_RET;
          end
          ST_RET: begin
            integ <= integ + err;
            if (err == 16'sh0000) begin
              elec     <= field_ang;
              turn     <= 8'h00;
              angle_ok <= 1'b1;
              refined  <= 1'b1;
              state    <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (motion && !refined && !method && hall_one) begin
              elec    <= bound;
              refined <= 1'b1;
            end else if (enc_up) begin
              elec <= up_sum[15:0];
              if (up_sum[16])
                turn <= (turn + 8'h01 >= {1'b0, pairs}) ? 8'h00 : turn + 8'h01;
            end else if (enc_dn) begin
              elec <= dn_dif[15:0];
              if (dn_dif[16])
                turn <= (turn == 8'h00) ? {1'b0, pairs} - 8'h01 : turn - 8'h01;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

/* verification/cia_motor_model.sv */
// Behavioural motor: Hall levels and a quadrature encoder moved by tasks.
// Assumes the bench calls its tasks right after a rising clock edge.
module cia_motor_model (
  // Clock
  input  wire logic       aclk,
  // Sensor pins
  output logic      [2:0] hall_in,
  output wire logic       enc_a,
  output wire logic       enc_b
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] ph;

  // Rotor at rest in sector 0
  initial begin
    hall_in = 3'h1;
    ph = 2'h0;
  end

  // Gray-coded quadrature, one line toggles per count
  assign enc_a = ph[1];
  assign enc_b = ph[1] ^ ph[0];

  // New Hall code; single-line changes unless a fault is staged
  task automatic set_hall(input logic [2:0] c);
    hall_in <= c;
  endtask

  // Shaft moves n counts, slow enough for the input synchronisers
  task automatic step(input int n);
    repeat (n) begin
      repeat (8) @(posedge aclk);
      ph <= ph + 2'h1;
    end
  endtask
endmodule

/* verification/cia_top_chk.sv */
// Checker for the register bus handshakes and reset state of cia_top.
// Assumes one clock domain and a synchronous active-low reset.
module cia_top_chk (
  // Clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // Bus handshakes
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wready,
  input wire logic         [1:0] s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic        [31:0] s_axi_rdata,
  input wire logic         [1:0] s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  // Current references
  input wire logic signed [15:0] phase_r_current,
  input wire logic signed [15:0] phase_s_current,
  input wire logic signed [15:0] phase_t_current
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Bus refusals and answer timing
  AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_AR_OPEN: assert property (!s_axi_rvalid |-> s_axi_arready)
    else $error("read address refused while idle");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after transfer");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after transfer");
  AST_BRESP: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response code");
  AST_RERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read returns data");
  // Drive is off coming out of reset
  AST_CUR_RESET: assert property ($rose(aresetn) |-> {phase_r_current, phase_s_current, phase_t_current} == 48'h0)
    else $error("currents not zero after reset");
endmodule

bind cia_top cia_top_chk cia_top_chk_i (
  .aclk            (aclk),
  .aresetn         (aresetn),
  .s_axi_awready   (s_axi_awready),
  .s_axi_wready    (s_axi_wready),
  .s_axi_bresp     (s_axi_bresp),
  .s_axi_bvalid    (s_axi_bvalid),
  .s_axi_bready    (s_axi_bready),
  .s_axi_arvalid   (s_axi_arvalid),
  .s_axi_arready   (s_axi_arready),
  .s_axi_rdata     (s_axi_rdata),
  .s_axi_rresp     (s_axi_rresp),
  .s_axi_rvalid    (s_axi_rvalid),
  .s_axi_rready    (s_axi_rready),
  .phase_r_current (phase_r_current),
  .phase_s_current (phase_s_current),
  .phase_t_current (phase_t_current)
);

/* verification/cia_top_tb.sv */
// Self-checking bench for cia_top: registers, Hall start, tracking, search.
// Assumes cia_consts.vh on the include path and the motor model beside it.
`include "cia_consts.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module cia_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} cia_row_t;
  // Address, write value, expected readback, expected response
  cia_row_t rows [6] = '{
    '{`CIA_REG_KP, 32'h0000_7FFF, 32'h0000_7FFF, 2'h0},
    '{`CIA_REG_KP, 32'h0000_8000, 32'h0000_7FFF, 2'h0},
    '{`CIA_REG_KI, 32'h0000_0064, 32'h0000_0064, 2'h0},
    '{`CIA_REG_POLES, 32'h0000_0006, 32'h0000_0006, 2'h0},
    '{8'h40, 32'h0000_1234, 32'h0000_0000, 2'h2},
    '{`CIA_REG_STEP, 32'h0000_0020, 32'h0000_0020, 2'h0}};
  logic        [2:0] hc [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic        [7:0] s_axi_awaddr = 8'h00;
  logic        [7:0] s_axi_araddr = 8'h00;
  logic       [31:0] s_axi_wdata = 32'h0000_0000;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_wvalid = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic        [3:0] s_axi_wstrb = 4'hF;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        [1:0] s_axi_bresp, s_axi_rresp, rp;
  logic       [31:0] s_axi_rdata, d, st, e;
  logic        [2:0] hall_in;
  logic              enc_a, enc_b;
  logic signed [15:0] phase_r_current, phase_s_current, phase_t_current;
  int                bad_count = 0;
  int                check_count = 0;
  int                cycles = 0;

  // 250 MHz clock
  always #2 aclk = ~aclk;

  cia_top #(.CLK_HZ(32'h0000_0064)) cia_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .hall_in(hall_in), .enc_a(enc_a), .enc_b(enc_b), .phase_r_current(phase_r_current),
    .phase_s_current(phase_s_current), .phase_t_current(phase_t_current));

  cia_motor_model cia_motor_model_i (.aclk(aclk), .hall_in(hall_in), .enc_a(enc_a), .enc_b(enc_b));

  // Verdict and end of run
  task print_verdict;
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Bus write: address and data together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Bus read
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rst(input int n);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Read status until a bit is set, bounded
  task automatic poll(input int b);
    int n = 0;
    do begin
      axr(`CIA_REG_STATUS, st, rp);
      n++;
    end while (st[b] !== 1'b1 && n < 400);
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      print_verdict;
    end
  end

  initial begin
    @(posedge aclk);
    rst(12);
    axr(`CIA_REG_KP, d, rp);
    `CHK("kp reset", 32'h0000_0400, d)
    // Table of register writes and readbacks
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].d, rp);
      `CHK("write resp", rows[i].r, rp)
      axr(rows[i].a, d, rp);
      `CHK("read data", rows[i].e, d)
      `CHK("read resp", rows[i].r, rp)
    end
    s_axi_wstrb <= 4'h1;
    axw(`CIA_REG_KP, 32'h0000_12AB, rp);
    s_axi_wstrb <= 4'hF;
    axr(`CIA_REG_KP, d, rp);
    `CHK("kp lane", 32'h0000_7FAB, d)
    // Hall start in every sector, no drive applied
    for (int i = 0; i < 6; i++) begin
      rst(3);
      cia_motor_model_i.set_hall(hc[i]);
      repeat (8) @(posedge aclk);
      axw(`CIA_REG_CTRL, 32'h0000_0002, rp);
      poll(`CIA_ST_VALID);
      `CHK("hall code", hc[i], st[10:8])
      axr(`CIA_REG_ANGLE, d, rp);
      `CHK("sector angle", 16'(i * `CIA_DEG60 + `CIA_DEG30), d[15:0])
      `CHK("mech angle", 16'((i * `CIA_DEG60 + `CIA_DEG30) % 65536 / 2), d[31:16])
      `CHK("idle drive", 48'h0, {phase_r_current, phase_s_current, phase_t_current})
    end
    // Motion from the estimate, then refinement at the boundary
    rst(3);
    cia_motor_model_i.set_hall(3'h3);
    repeat (8) @(posedge aclk);
    axw(`CIA_REG_CMD_CUR, 32'h0000_4000, rp);
    axw(`CIA_REG_CTRL, 32'h0000_0002, rp);
    poll(`CIA_ST_VALID);
    axw(`CIA_REG_CTRL, 32'h0000_0004, rp);
    repeat (8) @(posedge aclk);
    `CHK("drive at 90", 3'h7, {phase_r_current > 0, phase_s_current < 0, phase_t_current < 0})
    cia_motor_model_i.set_hall(3'h2);
    poll(`CIA_ST_REFINED);
    axr(`CIA_REG_ANGLE, d, rp);
    `CHK("boundary angle", 16'h5556, d[15:0])
    repeat (8) @(posedge aclk);
    `CHK("drive at 120", 3'h7, {phase_r_current > 0, phase_s_current < 256 && phase_s_current > -256,
         phase_t_current < 0})
    // Tracking by encoder counts alone
    cia_motor_model_i.step(4);
    repeat (8) @(posedge aclk);
    axr(`CIA_REG_ENC_POS, e, rp);
    axr(`CIA_REG_ANGLE, d, rp);
    `CHK("enc moved", 1'b1, e[15:0] != 16'h0000)
    `CHK("tracked angle", 16'(16'h5556 + e[15:0] * `CIA_STEP_RESET), d[15:0])
    // Illegal code, clear, then three lines at once
    cia_motor_model_i.set_hall(3'h7);
    poll(`CIA_ST_HALL_FLT);
    `CHK("code fault", 1'b1, st[2])
    cia_motor_model_i.set_hall(3'h2);
    repeat (8) @(posedge aclk);
    axw(`CIA_REG_STATUS, 32'h0000_000C, rp);
    axr(`CIA_REG_STATUS, st, rp);
    `CHK("faults cleared", 2'h0, st[3:2])
    cia_motor_model_i.set_hall(3'h5);
    poll(`CIA_ST_MULTI_FLT);
    `CHK("multi fault", 1'b1, st[3])
    // Phase search with final above initial and search longer than ramp
    rst(3);
    axw(`CIA_REG_RAMP_SEC, 32'h0000_0001, rp);
    axw(`CIA_REG_SRCH_SEC, 32'h0000_0002, rp);
    axw(`CIA_REG_I_INIT, 32'h0000_0000, rp);
    axw(`CIA_REG_I_FINAL, 32'h0000_0040, rp);
    axw(`CIA_REG_CTRL, 32'h0000_0003, rp);
    repeat (150) @(posedge aclk);
    `CHK("search drive", 1'b1, {phase_r_current, phase_s_current, phase_t_current} != 48'h0)
    poll(`CIA_ST_VALID);
    `CHK("search done", 3'h3, {st[4], st[1:0]})
    axr(`CIA_REG_ENC_POS, e, rp);
    `CHK("shaft home", 32'h0000_0000, e)
    print_verdict;
  end
endmodule
